// file: src/talk_status_pkg.sv
// shared constants and state types of the talker/status block
package talk_status_pkg;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [5:0] OFS_ISR = 6'h00;
	localparam logic [5:0] OFS_IMR = 6'h04;
	localparam logic [5:0] OFS_CSR = 6'h08;
	localparam logic [5:0] OFS_ASR = 6'h0C;
	localparam logic [5:0] OFS_AUX = 6'h10;
	localparam logic [5:0] OFS_ADR = 6'h14;
	localparam logic [5:0] OFS_SPR = 6'h18;
	localparam logic [5:0] OFS_DATA = 6'h1C;
	localparam logic [5:0] OFS_CPT = 6'h20;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int ISR_W = 5;
	localparam int ISR_TR = 0;
	localparam int ISR_BI = 1;
	localparam int ISR_END = 2;
	localparam int ISR_UNDEFINED_ADDR_CMD_STATUS = 3;
	localparam int ISR_SERIAL_POLL_ACTIVE = 4;
	localparam int CSR_UNDEFINED_ADDR_CMD_STATUS = 7;
	localparam int CSR_SERIAL_POLL_ACTIVE = 2;
	localparam int ASR_LISTENER_ACTIVE = 0;
	localparam int ASR_TALKER_ACTIVE = 1;
	localparam int ASR_MA = 2;
	localparam int ASR_ATN = 3;
	localparam int AUX_RESET = 7;
	localparam int AUX_FEOI = 5;
	localparam int AUX_DACR = 4;
	localparam int AUX_DACD = 1;
	localparam int SPR_RSV = 6;
	localparam logic [4:0] IMR_RST = 5'h00;
	localparam logic SRST_RST = 1'b1;
	// ****************************************
	// bus command codes, seven bits, with their group and low-nibble fields
	// ****************************************
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3F;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK = 2'h2;
	localparam logic [2:0] GRP_ACG = 3'h0;
	localparam logic [3:0] ACG_GTL = 4'h1;
	localparam logic [3:0] ACG_SDC = 4'h4;
	localparam logic [3:0] ACG_PPC = 4'h5;
	localparam logic [3:0] ACG_GET = 4'h8;
	localparam logic [3:0] ACG_TCT = 4'h9;
	// ****************************************
	// state machines
	// ****************************************
	typedef enum logic [1:0] {SRC_IDLE = 2'h0, SRC_DAV = 2'h1, SRC_WAIT = 2'h3} src_state_t;
	typedef enum logic [1:0] {ACC_READY = 2'h0, ACC_HOLD = 2'h1, ACC_DONE = 2'h3} acc_state_t;
endpackage

// file: src/irq_edge_gen.sv
// interrupt request on rising edge of the enabled status
`timescale 1ns/1ps
module irq_edge_gen (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [talk_status_pkg::ISR_W-1:0] status_i,
	input wire logic [talk_status_pkg::ISR_W-1:0] mask_i,
	input wire logic clr_i,
	input wire logic srst_i,
	output logic irq_n_o
);
	import talk_status_pkg::*;

	typedef struct packed {
		logic any;
		logic irq_n;
	} irq_state_t;

	irq_state_t q;
	irq_state_t d;
	logic any_now;

	// only a low-to-high of the enabled or requests
	always_comb begin
		d = q;
		any_now = |(status_i & mask_i);
		d.any = any_now;
		if (clr_i || srst_i) begin
			d.irq_n = 1'b1;
		end
		if (any_now && !q.any && !srst_i) begin
			d.irq_n = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '{any: 1'b0, irq_n: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign irq_n_o = q.irq_n;

	property p_irq_edge;
		@(posedge core_clk_i) disable iff (!rstn_i)
		any_now && !q.any && !srst_i |=> !q.irq_n;
	endproperty
	a_irq_edge: assert property (p_irq_edge) else $error("irq missed an edge");

	property p_irq_cause;
		@(posedge core_clk_i) disable iff (!rstn_i)
		$fell(q.irq_n) |-> $past(any_now) && !$past(q.any);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled edge");
endmodule

// file: src/talker_status_core.sv
// talker source handshake, status flags and force-end logic
// Behaviour
// - serial poll active entered after enable, my talk address, then ATN released
// - disable before status byte taken leaves poll-byte-pending set
// - pending poll byte and talker: resend data register byte on every RFD
// - repeating stops only after the status byte handshake in serial poll or a reset
// - poll status bit set by enable plus talk address, cleared by disable
// - talker-ready set while talker with empty data register and after accept
// - untalk clears talker-ready even with an unserviced interrupt
// - undefined addressed command flag set whether addressed or not
// - listener or talker active bit set once ATN goes false
// - end flag set when talker marks last byte, ahead of the byte
// - end flag has its own interrupt mask bit
// - force-end set by writing one, clears itself one clock later
// - force-end as talker drives EOI until next data byte accepted; a status byte in serial poll leaves it set
// - force-end while not talker is kept until next talker state
// - only a reset cancels a registered force-end
// - status bit reaches interrupt only when its mask bit is set
// - interrupt fires only on rising edge of enabled status or
// - reset clears interrupts and idles the interface functions
`timescale 1ns/1ps
module talker_status_core (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [5:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	input wire logic atn_i,
	input wire logic eoi_i,
	input wire logic [7:0] dio_i,
	input wire logic dav_i,
	input wire logic rfd_i,
	input wire logic dac_i,
	output logic [7:0] dio_o,
	output logic dio_oe_o,
	output logic dav_o,
	output logic dav_oe_o,
	output logic eoi_o,
	output logic eoi_oe_o,
	output logic rfd_o,
	output logic rfd_oe_o,
	output logic dac_o,
	output logic dac_oe_o,
	output logic irq_n_o
);
	import talk_status_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic waitreq;
		logic [7:0] rdata;
		logic [ISR_W-1:0] imr;
		logic srst;
		logic dacd;
		logic feoi;
		logic dacr;
		logic [4:0] paddr;
		logic [7:0] spoll;
		logic [7:0] odr;
		logic odr_full;
		logic [7:0] idr;
		logic talk_addr;
		logic listen_addr;
		logic spms;
		logic talker_active;
		logic listener_active;
		logic serial_poll_active;
		logic sp_st;
		logic poll_pending;
		logic eoi_pending;
		logic talker_ready;
		logic byte_rcvd;
		logic end_st;
		logic undefined_addr_cmd_status_st;
		src_state_t src;
		acc_state_t acc;
		logic [7:0] dio;
		logic dio_oe;
		logic dav;
		logic eoi;
		logic rfd_oe;
		logic dac_oe;
	} core_state_t;

	core_state_t q;
	core_state_t d;
	logic req;
	logic acc;
	logic wr;
	logic rd;
	logic wr_aux;
	logic wr_data;
	logic accept;
	logic cmd_take;
	logic isr_rd;
	logic acc_on;
	logic talker_active_n;
	logic [6:0] cmd;
	logic [7:0] rval;
	logic [ISR_W-1:0] isr;

	// undefined member of the addressed command group
	function automatic logic is_undefined_addr_cmd_status(input logic [6:0] c);
		is_undefined_addr_cmd_status = (c[6:4] == GRP_ACG) && (c[3:0] != ACG_GTL) && (c[3:0] != ACG_SDC)
			&& (c[3:0] != ACG_PPC) && (c[3:0] != ACG_GET) && (c[3:0] != ACG_TCT);
	endfunction

	// own listen or talk address in a group
	function automatic logic is_mine(input logic [6:0] c, input logic [1:0] g,
		input logic [4:0] a);
		is_mine = (c == {g, a});
	endfunction

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		d = q;
		cmd = dio_i[6:0];
		req = read_i || write_i;
		acc = req && !q.waitreq;
		wr = write_i && acc && byteenable_i[0];
		rd = read_i && acc;
		wr_aux = wr && (address_i == OFS_AUX);
		wr_data = wr && (address_i == OFS_DATA);
		isr_rd = rd && (address_i == OFS_ISR);
		accept = 1'b0;
		cmd_take = 1'b0;
		acc_on = atn_i || q.listener_active;
		talker_active_n = q.talk_addr && !atn_i && !q.srst;
		isr = {q.sp_st, q.undefined_addr_cmd_status_st, q.end_st, q.byte_rcvd, q.talker_ready};
		rval = 8'h00;

		// bus slave: one wait cycle, then the answer
		d.waitreq = !(req && q.waitreq);
		if (address_i == OFS_ISR) begin
			rval = {3'h0, isr};
		end else if (address_i == OFS_IMR) begin
			rval = {3'h0, q.imr};
		end else if (address_i == OFS_CSR) begin
			rval = {q.undefined_addr_cmd_status_st, 4'h0, q.sp_st, 2'h0};
		end else if (address_i == OFS_ASR) begin
			rval = {4'h0, atn_i, q.talk_addr || q.listen_addr, q.talker_active, q.listener_active};
		end else if (address_i == OFS_AUX) begin
			rval = {q.srst, 7'h00};
		end else if (address_i == OFS_ADR) begin
			rval = {3'h0, q.paddr};
		end else if (address_i == OFS_SPR) begin
			rval = q.spoll;
		end else if (address_i == OFS_DATA) begin
			rval = q.idr;
		end else if (address_i == OFS_CPT) begin
			rval = dio_i;
		end
		if (req && q.waitreq) begin
			d.rdata = rval;
		end

		// register writes; strobes last one clock
		d.feoi = 1'b0;
		d.dacr = 1'b0;
		if (wr && (address_i == OFS_IMR)) begin
			d.imr = writedata_i[ISR_W-1:0];
		end
		if (wr_aux) begin
			d.srst = writedata_i[AUX_RESET];
			d.dacd = writedata_i[AUX_DACD];
			d.feoi = writedata_i[AUX_FEOI];
			d.dacr = writedata_i[AUX_DACR];
		end
		if (wr && (address_i == OFS_ADR)) begin
			d.paddr = writedata_i[4:0];
		end
		if (wr && (address_i == OFS_SPR)) begin
			d.spoll = writedata_i[7:0];
		end

		// read side effects clear first so a new event wins
		if (isr_rd) begin
			d.end_st = 1'b0;
		end
		if (rd && (address_i == OFS_CSR)) begin
			d.undefined_addr_cmd_status_st = 1'b0;
		end
		if (rd && (address_i == OFS_DATA)) begin
			d.byte_rcvd = 1'b0;
		end

		// active states follow addressing once ATN is false
		d.talker_active = talker_active_n;
		d.listener_active = q.listen_addr && !atn_i && !q.srst;
		d.serial_poll_active = q.spms && talker_active_n;
		if (d.serial_poll_active && !q.serial_poll_active) begin
			d.poll_pending = 1'b1;
			d.spoll[SPR_RSV] = 1'b0;
		end

		// source handshake; status byte in poll, else data register
		case (q.src)
			SRC_IDLE: begin
				if (q.talker_active && (q.serial_poll_active ? q.poll_pending : q.odr_full) && rfd_i && !dac_i) begin
					d.dio = q.serial_poll_active ? q.spoll : q.odr;
					d.src = SRC_DAV;
				end
			end
			SRC_DAV: begin
				if (!talker_active_n) begin
					d.src = SRC_IDLE;
				end else if (dac_i) begin
					accept = 1'b1;
					d.src = SRC_WAIT;
				end
			end
			SRC_WAIT: begin
				if (!dac_i || !talker_active_n) begin
					d.src = SRC_IDLE;
				end
			end
			default: begin
				d.src = SRC_IDLE;
			end
		endcase

		// accepted byte: poll byte ends pending, data byte may repeat
		if (accept && q.serial_poll_active) begin
			d.poll_pending = 1'b0;
		end else if (accept) begin
			if (!q.poll_pending) begin
				d.odr_full = 1'b0;
			end
			d.eoi_pending = 1'b0;
		end
		if (wr_data) begin
			d.odr = writedata_i[7:0];
			d.odr_full = 1'b1;
		end
		if (q.feoi) begin
			d.eoi_pending = 1'b1;
		end

		// talker-ready follows talker state and the data register
		if (!talker_active_n) begin
			d.talker_ready = 1'b0;
		end else if (accept && !q.serial_poll_active) begin
			d.talker_ready = 1'b1;
		end else if (wr_data) begin
			d.talker_ready = 1'b0;
		end else if (!q.odr_full) begin
			d.talker_ready = 1'b1;
		end

		// acceptor for commands and, when listening, data
		case (q.acc)
			ACC_READY: begin
				if (acc_on && dav_i && !q.srst) begin
					if (atn_i) begin
						cmd_take = 1'b1;
						d.acc = (q.dacd || is_undefined_addr_cmd_status(cmd)) ? ACC_HOLD : ACC_DONE;
					end else begin
						d.idr = dio_i;
						d.byte_rcvd = 1'b1;
						d.acc = ACC_DONE;
					end
				end
			end
			ACC_HOLD: begin
				if (q.dacr) begin
					d.acc = ACC_DONE;
				end
			end
			ACC_DONE: begin
				if (!dav_i) begin
					d.acc = ACC_READY;
				end
			end
			default: begin
				d.acc = ACC_READY;
			end
		endcase

		// command decode
		if (cmd_take) begin
			if (is_mine(cmd, GRP_LISTEN, q.paddr)) begin
				d.listen_addr = 1'b1;
				d.talk_addr = 1'b0;
			end else if (cmd == CMD_UNL) begin
				d.listen_addr = 1'b0;
			end else if (is_mine(cmd, GRP_TALK, q.paddr)) begin
				d.talk_addr = 1'b1;
			end else if (cmd[6:5] == GRP_TALK) begin
				d.talk_addr = 1'b0;
			end else if (cmd == CMD_SPE) begin
				d.spms = 1'b1;
			end else if (cmd == CMD_SPD) begin
				d.spms = 1'b0;
			end else if (is_undefined_addr_cmd_status(cmd)) begin
				d.undefined_addr_cmd_status_st = 1'b1;
			end
		end

		// end flag is a level, independent of the handshake
		if (q.listener_active && !atn_i && eoi_i) begin
			d.end_st = 1'b1;
		end
		d.sp_st = d.spms && d.talk_addr;

		// soft reset idles the interface functions
		if (q.srst) begin
			d.talk_addr = 1'b0;
			d.listen_addr = 1'b0;
			d.spms = 1'b0;
			d.sp_st = 1'b0;
			d.poll_pending = 1'b0;
			d.eoi_pending = 1'b0;
			d.talker_ready = 1'b0;
			d.byte_rcvd = 1'b0;
			d.end_st = 1'b0;
			d.undefined_addr_cmd_status_st = 1'b0;
			d.odr_full = 1'b0;
			d.src = SRC_IDLE;
			d.acc = ACC_READY;
		end

		// pin drives
		d.dio_oe = talker_active_n;
		d.dav = (d.src == SRC_DAV);
		d.eoi = d.eoi_pending && talker_active_n;
		d.rfd_oe = (d.acc != ACC_READY);
		d.dac_oe = (acc_on && (d.acc == ACC_READY)) || (d.acc == ACC_HOLD);
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
			q.waitreq <= 1'b1;
			q.imr <= IMR_RST;
			q.srst <= SRST_RST;
			q.src <= SRC_IDLE;
			q.acc <= ACC_READY;
		end else begin
			q <= d;
		end
	end

	// interrupt request, masked per status bit including end
	irq_edge_gen u_irq (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.status_i(isr),
		.mask_i(q.imr),
		.clr_i(isr_rd),
		.srst_i(q.srst),
		.irq_n_o(irq_n_o)
	);

	// outputs; open-drain lines only ever pull low
	assign readdata_o = {24'h000000, q.rdata};
	assign waitrequest_o = q.waitreq;
	assign dio_o = q.dio;
	assign dio_oe_o = q.dio_oe;
	assign dav_o = q.dav;
	assign dav_oe_o = q.dio_oe;
	assign eoi_o = q.eoi;
	assign eoi_oe_o = q.dio_oe;
	assign rfd_o = 1'b0;
	assign rfd_oe_o = q.rfd_oe;
	assign dac_o = 1'b0;
	assign dac_oe_o = q.dac_oe;

	// ****************************************
	// checks
	// ****************************************
	sequence s_feoi_wr;
		wr_aux && writedata_i[AUX_FEOI];
	endsequence
	sequence s_pulse;
		q.feoi ##1 !q.feoi;
	endsequence
	property p_feoi_pulse;
		@(posedge core_clk_i) disable iff (!rstn_i)
		s_feoi_wr |=> s_pulse;
	endproperty
	a_feoi_pulse: assert property (p_feoi_pulse) else $error("force-end not one clock");

	property p_eoi_hold;
		@(posedge core_clk_i) disable iff (!rstn_i)
		q.eoi_pending && !accept && !q.srst |=> q.eoi_pending;
	endproperty
	a_eoi_hold: assert property (p_eoi_hold) else $error("end message lost");

	property p_eoi_release;
		@(posedge core_clk_i) disable iff (!rstn_i)
		accept && !q.serial_poll_active && !q.feoi |=> !q.eoi_pending ##1 (!q.eoi || $past(q.feoi));
	endproperty
	a_eoi_release: assert property (p_eoi_release) else $error("eoi kept after accept");

	property p_eoi_later;
		@(posedge core_clk_i) disable iff (!rstn_i)
		q.eoi_pending && !q.talker_active && !q.srst ##1 q.talker_active |-> q.eoi;
	endproperty
	a_eoi_later: assert property (p_eoi_later) else $error("eoi not on talker entry");

	property p_untalk_tr;
		@(posedge core_clk_i) disable iff (!rstn_i)
		$past(q.talker_ready) && $fell(q.talker_active) |-> !q.talker_ready;
	endproperty
	a_untalk_tr: assert property (p_untalk_tr) else $error("talker-ready after untalk");

	property p_repeat;
		@(posedge core_clk_i) disable iff (!rstn_i)
		accept && !q.serial_poll_active && q.poll_pending && !q.srst |=> q.odr_full && q.talker_ready;
	endproperty
	a_repeat: assert property (p_repeat) else $error("byte not repeated");

	property p_poll_clear;
		@(posedge core_clk_i) disable iff (!rstn_i)
		accept && q.serial_poll_active |=> !q.poll_pending;
	endproperty
	a_poll_clear: assert property (p_poll_clear) else $error("pending not cleared");

	property p_poll_set;
		@(posedge core_clk_i) disable iff (!rstn_i)
		!q.serial_poll_active ##1 q.serial_poll_active |-> q.poll_pending;
	endproperty
	a_poll_set: assert property (p_poll_set) else $error("pending not set on poll");

	property p_undefined_addr_cmd_status;
		@(posedge core_clk_i) disable iff (!rstn_i)
		cmd_take && is_undefined_addr_cmd_status(cmd) |=> q.undefined_addr_cmd_status_st;
	endproperty
	a_undefined_addr_cmd_status: assert property (p_undefined_addr_cmd_status) else $error("undefined command flag missed");

	property p_listener_active;
		@(posedge core_clk_i) disable iff (!rstn_i)
		q.listen_addr && !atn_i && !q.srst |=> q.listener_active;
	endproperty
	a_listener_active: assert property (p_listener_active) else $error("listener active not set");

	property p_spd;
		@(posedge core_clk_i) disable iff (!rstn_i)
		cmd_take && (cmd == CMD_SPD) |=> !q.sp_st;
	endproperty
	a_spd: assert property (p_spd) else $error("poll status after disable");
endmodule

// file: sim/bus_partner.sv
// controller and listener model on the far side of the instrument bus
`timescale 1ns/1ps
module bus_partner (
	input wire logic core_clk_i,
	input wire logic dav_i,
	input wire logic dac_i,
	input wire logic eoi_i,
	input wire logic [7:0] dio_i,
	output logic atn_o,
	output logic dav_o,
	output logic eoi_o,
	output logic rfd_o,
	output logic dac_o,
	output logic [7:0] dio_o
);
	// idle: listener pulls rfd and dac false
	initial begin
		atn_o = 1'b0;
		dav_o = 1'b0;
		eoi_o = 1'b0;
		rfd_o = 1'b0;
		dac_o = 1'b0;
		dio_o = 8'h00;
	end
	// controller sends a command byte with attention true
	task cmd_start(input logic [7:0] c);
		@(posedge core_clk_i);
		atn_o <= 1'b1;
		rfd_o <= 1'b1;
		dac_o <= 1'b1;
		dio_o <= c;
		@(posedge core_clk_i);
		dav_o <= 1'b1;
	endtask
	// finish the command handshake once the device accepts
	task cmd_finish;
		do @(posedge core_clk_i); while (dac_i !== 1'b1);
		dav_o <= 1'b0;
		dio_o <= ~dio_o; // released lines keep no stale value
		do @(posedge core_clk_i); while (dac_i !== 1'b0);
	endtask
	task cmd(input logic [7:0] c);
		cmd_start(c);
		cmd_finish();
	endtask
	task release_atn;
		@(posedge core_clk_i);
		atn_o <= 1'b0;
		rfd_o <= 1'b0;
		dac_o <= 1'b0;
	endtask
	// listener accepts one byte from the talking device
	task accept(output logic [7:0] d, output logic e);
		@(posedge core_clk_i);
		rfd_o <= 1'b1;
		do @(posedge core_clk_i); while (dav_i !== 1'b1);
		d = dio_i;
		e = eoi_i;
		rfd_o <= 1'b0;
		dac_o <= 1'b1;
		do @(posedge core_clk_i); while (dav_i !== 1'b0);
		dac_o <= 1'b0;
	endtask
	// talker on the far side puts a data byte up with attention false
	task send_start(input logic [7:0] v, input logic last);
		@(posedge core_clk_i);
		rfd_o <= 1'b1;
		dac_o <= 1'b1;
		eoi_o <= last;
		dio_o <= v;
	endtask
	// raise data valid and finish the handshake with the listening device
	task send_finish;
		@(posedge core_clk_i);
		dav_o <= 1'b1;
		do @(posedge core_clk_i); while (dac_i !== 1'b1);
		dav_o <= 1'b0;
		eoi_o <= 1'b0;
		dio_o <= ~dio_o;
		do @(posedge core_clk_i); while (dac_i !== 1'b0);
		rfd_o <= 1'b0;
		dac_o <= 1'b0;
	endtask
	// ready for a while and report any data valid seen
	task quiet(output logic saw);
		saw = 1'b0;
		@(posedge core_clk_i);
		rfd_o <= 1'b1;
		repeat (20) begin
			@(posedge core_clk_i);
			if (dav_i === 1'b1)
				saw = 1'b1;
		end
		rfd_o <= 1'b0;
	endtask
endmodule

// file: sim/tb.sv
// self-checking bench of the talker and status block
`timescale 1ns/1ps
module tb;
	import talk_status_pkg::*;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [5:0] address_i = 6'h00;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [31:0] writedata_i = 32'h0;
	logic [31:0] readdata_o;
	logic waitrequest_o, dio_oe_o, dav_o, dav_oe_o, eoi_o, eoi_oe_o;
	logic rfd_o, rfd_oe_o, dac_o, dac_oe_o, irq_n_o;
	logic m_atn, m_dav, m_eoi, m_rfd, m_dac;
	logic [7:0] dio_o, m_dio, dio_i;
	logic dav_i, eoi_i, rfd_i, dac_i, e, saw;
	logic [7:0] b;
	logic [31:0] d;
	int n_fail = 0;
	int comparisons = 0;
	localparam logic [7:0] MTA = {1'b0, GRP_TALK, 5'h05};
	localparam logic [7:0] UNT = {1'b0, GRP_TALK, 5'h1F};
	// ****************************************
	// wire resolution of the shared bus lines
	// ****************************************
	assign dav_i = dav_oe_o ? dav_o : m_dav;
	assign eoi_i = eoi_oe_o ? eoi_o : m_eoi;
	assign dio_i = dio_oe_o ? dio_o : m_dio;
	assign rfd_i = m_rfd & ~rfd_oe_o;
	assign dac_i = m_dac & ~dac_oe_o;
	talker_status_core u_talker_status_core (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.address_i(address_i), .read_i(read_i), .write_i(write_i), .byteenable_i(4'hF),
		.writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.atn_i(m_atn), .eoi_i(eoi_i), .dio_i(dio_i), .dav_i(dav_i), .rfd_i(rfd_i),
		.dac_i(dac_i), .dio_o(dio_o), .dio_oe_o(dio_oe_o), .dav_o(dav_o),
		.dav_oe_o(dav_oe_o), .eoi_o(eoi_o), .eoi_oe_o(eoi_oe_o), .rfd_o(rfd_o),
		.rfd_oe_o(rfd_oe_o), .dac_o(dac_o), .dac_oe_o(dac_oe_o), .irq_n_o(irq_n_o));
	bus_partner u_bus_partner (.core_clk_i(core_clk_i), .dav_i(dav_i), .dac_i(dac_i),
		.eoi_i(eoi_i), .dio_i(dio_i), .atn_o(m_atn), .dav_o(m_dav), .eoi_o(m_eoi),
		.rfd_o(m_rfd), .dac_o(m_dac), .dio_o(m_dio));
	// 20 MHz clock
	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end
	// ****************************************
	// helpers
	// ****************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task conclude;
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// avalon read, held until waitrequest sampled low
	task bus_rd(input logic [5:0] a, output logic [31:0] q);
		@(posedge core_clk_i);
		address_i <= a;
		read_i <= 1'b1;
		do @(posedge core_clk_i); while (waitrequest_o !== 1'b0);
		q = readdata_o;
		read_i <= 1'b0;
	endtask
	task bus_wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge core_clk_i);
		address_i <= a;
		writedata_i <= {24'h0, v};
		write_i <= 1'b1;
		do @(posedge core_clk_i); while (waitrequest_o !== 1'b0);
		write_i <= 1'b0;
	endtask
	task talk(input logic [7:0] c);
		u_bus_partner.cmd(c);
		u_bus_partner.release_atn();
	endtask
	task take(input logic [7:0] v, input logic ev);
		u_bus_partner.accept(b, e);
		chk({24'h0, b}, {24'h0, v});
		chk({31'h0, e}, {31'h0, ev});
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_setup;
		bus_rd(OFS_IMR, d);
		chk(d, 32'h0);
		bus_rd(6'h24, d);
		chk(d, 32'h0);
		bus_wr(OFS_AUX, 8'h00);
		bus_wr(OFS_ADR, 8'h05); // address kept clear of 31
		bus_wr(OFS_IMR, 8'h01);
	endtask
	// undefined command while unaddressed, held until release
	task t_undefined_addr_cmd_status;
		u_bus_partner.cmd_start(8'h02);
		bus_rd(OFS_CSR, d);
		chk(d & 32'h80, 32'h80);
		bus_wr(OFS_AUX, 8'h10);
		u_bus_partner.cmd_finish();
		u_bus_partner.release_atn();
	endtask
	// force-end written before becoming talker
	task t_feoi;
		bus_wr(OFS_AUX, 8'h20);
		talk(MTA);
		bus_rd(OFS_ASR, d);
		chk(d & 32'h2, 32'h2);
		chk({31'h0, irq_n_o}, 32'h0);
		bus_rd(OFS_ISR, d);
		chk(d & 32'h1, 32'h1);
		bus_wr(OFS_DATA, 8'hA5);
		take(8'hA5, 1'b1);
		bus_wr(OFS_DATA, 8'h3C);
		take(8'h3C, 1'b0);
		bus_rd(OFS_ISR, d);
		chk(d & 32'h1, 32'h1);
	endtask
	task t_untalk;
		talk(UNT);
		bus_rd(OFS_ISR, d);
		chk(d & 32'h1, 32'h0);
		bus_rd(OFS_ASR, d);
		chk(d & 32'h2, 32'h0);
	endtask
	// poll abandoned, then bytes repeat until the poll completes
	task t_poll;
		bus_wr(OFS_SPR, 8'h41);
		u_bus_partner.cmd({1'b0, CMD_SPE});
		talk(MTA);
		bus_rd(OFS_CSR, d);
		chk(d & 32'h4, 32'h4);
		bus_rd(OFS_SPR, d);
		chk(d & 32'h40, 32'h0);
		talk({1'b0, CMD_SPD});
		bus_rd(OFS_CSR, d);
		chk(d & 32'h4, 32'h0);
		bus_wr(OFS_DATA, 8'h77);
		talk(MTA);
		take(8'h77, 1'b0);
		take(8'h77, 1'b0);
		u_bus_partner.cmd({1'b0, CMD_SPE});
		talk(MTA);
		u_bus_partner.accept(b, e);
		chk({24'h0, b}, 32'h01);
		talk({1'b0, CMD_SPD});
		bus_wr(OFS_DATA, 8'h12);
		take(8'h12, 1'b0);
		u_bus_partner.quiet(saw);
		chk({31'h0, saw}, 32'h0);
	endtask
	// listener: end flag ahead of the byte, no second request while one bit stands
	task t_listen;
		bus_wr(OFS_IMR, 8'h06);
		talk({1'b0, GRP_LISTEN, 5'h05});
		bus_rd(OFS_ISR, d);
		chk(d, 32'h0);
		u_bus_partner.send_start(8'h5A, 1'b1);
		bus_rd(OFS_ASR, d);
		chk(d & 32'h3, 32'h1);
		chk({31'h0, irq_n_o}, 32'h0);
		bus_rd(OFS_ISR, d);
		chk(d, 32'h4);
		u_bus_partner.send_finish();
		chk({31'h0, irq_n_o}, 32'h1);
		bus_rd(OFS_ISR, d);
		chk(d, 32'h6);
		bus_rd(OFS_DATA, d);
		chk(d, 32'h5A);
	endtask
	// reset in mid-run, then soft reset back on and status clear
	task t_reset;
		@(posedge core_clk_i);
		rstn_i <= 1'b0;
		@(posedge core_clk_i);
		chk({30'h0, irq_n_o, dav_oe_o}, 32'h2);
		rstn_i <= 1'b1;
		bus_rd(OFS_AUX, d);
		chk(d, 32'h80);
		bus_rd(OFS_ISR, d);
		chk(d, 32'h0);
	endtask
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		repeat (4) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		t_setup();
		t_undefined_addr_cmd_status();
		t_feoi();
		t_untalk();
		t_poll();
		t_listen();
		t_reset();
		conclude();
	end
	initial begin
		#1000000;
		n_fail++;
		conclude();
	end
endmodule
